/* File: inc/tape_buffer_pkg.sv */
// Purpose: shared constants and types for the tape staging buffer control
// Assumes: occupancy and thresholds are counted in 4-KByte buffer units
// Notes: tape-side rates are in half-KByte-per-second steps

package tape_buffer_pkg;
  // buffer geometry, in 4-KByte units
  localparam int UNIT_KBYTES = 4;
  localparam int OCC_W = 9;
  localparam logic [8:0] CAP_UNITS = 9'h100;
  localparam logic [8:0] OCC_RESET = 9'h000;
  // thresholds
  localparam int THR_W = 8;
  localparam logic [7:0] THR_RESET = 8'h80;
  // mode select command
  localparam logic [7:0] OP_MODE_SELECT = 8'h15;
  localparam logic SEL_MOTION = 1'b0;
  localparam logic SEL_RECON = 1'b1;
  // tape-side rates, 0.5 KB/s steps: 1 MB/s, 500 KB/s, 262.5 KB/s
  localparam int RATE_W = 16;
  localparam logic [15:0] RATE_1M = 16'h07D0;
  localparam logic [15:0] RATE_500K = 16'h03E8;
  localparam logic [15:0] RATE_262K5 = 16'h020D;

  typedef enum logic [1:0] {
    FMT_HI_COMP = 2'b00,
    FMT_HI = 2'b01,
    FMT_LO_COMP = 2'b10,
    FMT_LO = 2'b11
  } fmt_e;

  typedef enum logic {
    TAPE_STOP = 1'b0,
    TAPE_MOVE = 1'b1
  } tape_st_e;

  typedef enum logic {
    HOST_OFF = 1'b0,
    HOST_ON = 1'b1
  } host_st_e;

  // tape-side sustained rate for each format
  function automatic logic [15:0] tape_rate(input fmt_e f);
    case (f)
      FMT_HI_COMP: tape_rate = RATE_1M;
      FMT_HI: tape_rate = RATE_500K;
      FMT_LO_COMP: tape_rate = RATE_500K;
      default: tape_rate = RATE_262K5;
    endcase
  endfunction

  // strictly greater-than against an 8-bit threshold
  function automatic logic above(input logic [8:0] amount, input logic [7:0] thr);
    above = amount > {1'b0, thr};
  endfunction
endpackage

/* File: logic/thr_regs.sv */
// Purpose: motion and reconnect thresholds written by mode select
// Assumes: one command a cycle, commands synchronous to clk
// Notes: other opcodes are ignored

`timescale 1ns/100ps

module thr_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic cmd_sel,
  input wire logic [7:0] cmd_value,
  // thresholds
  output logic [7:0] motion_thr_q,
  output logic [7:0] recon_thr_q
);
  logic mode_sel;

  assign mode_sel = cmd_valid && (cmd_opcode == tape_buffer_pkg::OP_MODE_SELECT);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      motion_thr_q <= tape_buffer_pkg::THR_RESET;
    end else if (mode_sel && cmd_sel == tape_buffer_pkg::SEL_MOTION) begin
      motion_thr_q <= cmd_value;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      recon_thr_q <= tape_buffer_pkg::THR_RESET;
    end else if (mode_sel && cmd_sel == tape_buffer_pkg::SEL_RECON) begin
      recon_thr_q <= cmd_value;
    end
  end
endmodule // thr_regs

/* File: logic/occ_count.sv */
// Purpose: buffer occupancy counter in 4-KByte units
// Assumes: inc only when not full, dec only when not empty
// Notes: saturates at both ends as a guard

`timescale 1ns/100ps

module occ_count (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // unit moves
  input wire logic inc,
  input wire logic dec,
  // occupancy
  output logic [8:0] occ_q
);
  logic [8:0] occ_d;

  always_comb begin
    occ_d = occ_q;
    if (inc && !dec && occ_q != tape_buffer_pkg::CAP_UNITS) begin
      occ_d = occ_q + 9'h001;
    end else if (dec && !inc && occ_q != 9'h000) begin
      occ_d = occ_q - 9'h001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      occ_q <= tape_buffer_pkg::OCC_RESET;
    end else begin
      occ_q <= occ_d;
    end
  end
endmodule // occ_count

/* File: logic/tape_buffer_ctrl.sv */
// Purpose: threshold control of tape motion and host connection around a 1-MByte staging buffer
// Assumes: one pulse on host_unit or tape_unit moves one 4-KByte unit; inputs synchronous to clk
// Notes: the buffer data path itself sits outside; this block only counts and steers
// Contract
// - motion threshold held, in 4-KByte units, governs start/stop tape transfers
// - motion threshold resets to 80h, half the buffer
// - mode select 15h rewrites motion threshold; later transfers use it
// - buffer is 1 MByte; comparisons use occupancy or free space
// - start/stop write: tape starts only when data exceeds motion threshold; the code also starts on flush_req with data held, before any halt too
// - start/stop write: keep writing until empty, then halt
// - after halt, restart on data above threshold or a flush request
// - start/stop read: tape starts only when free space exceeds threshold
// - start/stop read: read until full, halt, restart on free above threshold
// - reconnect threshold, 4-KByte units, resets 80h, rewritten by mode select
// - streaming write: disconnect host when full, keep draining to tape
// - streaming write: reconnect when free exceeds reconnect threshold, fill until full
// - streaming read: disconnect host when empty, keep filling from tape
// - streaming read: reconnect when data exceeds reconnect threshold, send until empty
// - streaming when host rate reaches format tape rate, else start/stop
// - counts are of compressed bytes held in the buffer

`timescale 1ns/100ps

module tape_buffer_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // mode select command
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic cmd_sel,
  input wire logic [7:0] cmd_value,
  // operation setup
  input wire logic dir_write,
  input wire tape_buffer_pkg::fmt_e fmt,
  input wire logic [15:0] host_rate,
  input wire logic flush_req,
  // unit transfers
  input wire logic host_unit,
  input wire logic tape_unit,
  output logic host_ready,
  output logic tape_ready,
  // status
  output logic tape_motion_q,
  output logic host_conn_q,
  output logic stream_q,
  output logic [8:0] occ_units_q,
  output logic [8:0] free_units_q,
  output logic [7:0] motion_thr_q,
  output logic [7:0] recon_thr_q
);
  tape_buffer_pkg::tape_st_e tape_st_q;
  tape_buffer_pkg::tape_st_e tape_st_d;
  tape_buffer_pkg::host_st_e host_st_q;
  tape_buffer_pkg::host_st_e host_st_d;
  logic [8:0] occ_q;
  logic [8:0] free_units;
  logic full;
  logic empty;
  logic host_take;
  logic tape_take;
  logic fill;
  logic drain;
  logic data_above_motion;
  logic free_above_motion;
  logic data_above_recon;
  logic free_above_recon;
  logic stream_d;

  thr_regs u_thr (
    .clk(clk),
    .rst(rst),
    .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode),
    .cmd_sel(cmd_sel),
    .cmd_value(cmd_value),
    .motion_thr_q(motion_thr_q),
    .recon_thr_q(recon_thr_q)
  );

  // free space derived from occupancy; free_units_q is registered from the next occupancy, so the two cannot drift
  assign free_units = tape_buffer_pkg::CAP_UNITS - occ_q;
  assign full = (occ_q == tape_buffer_pkg::CAP_UNITS);
  assign empty = (occ_q == 9'h000);

  // thresholds compare buffer units, which hold compressed data in compressed formats
  assign data_above_motion = tape_buffer_pkg::above(occ_q, motion_thr_q);
  assign free_above_motion = tape_buffer_pkg::above(free_units, motion_thr_q);
  assign data_above_recon = tape_buffer_pkg::above(occ_q, recon_thr_q);
  assign free_above_recon = tape_buffer_pkg::above(free_units, recon_thr_q);

  // handshakes: the filling side stalls on full, the draining side on empty
  always_comb begin
    if (dir_write) begin
      host_ready = (host_st_q == tape_buffer_pkg::HOST_ON) && !full;
      tape_ready = (tape_st_q == tape_buffer_pkg::TAPE_MOVE) && !empty;
    end else begin
      host_ready = (host_st_q == tape_buffer_pkg::HOST_ON) && !empty;
      tape_ready = (tape_st_q == tape_buffer_pkg::TAPE_MOVE) && !full;
    end
  end

  assign host_take = host_unit && host_ready;
  assign tape_take = tape_unit && tape_ready;
  assign fill = dir_write ? host_take : tape_take;
  assign drain = dir_write ? tape_take : host_take;

  occ_count u_occ (
    .clk(clk),
    .rst(rst),
    .inc(fill),
    .dec(drain),
    .occ_q(occ_q)
  );

  // streaming when the host keeps up with the tape side of the chosen format
  assign stream_d = (host_rate >= tape_buffer_pkg::tape_rate(fmt));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stream_q <= 1'b0;
    end else begin
      stream_q <= stream_d;
    end
  end

  // tape motion
  always_comb begin
    tape_st_d = tape_st_q;
    case ({dir_write, stream_q})
      2'b10: begin
        case (tape_st_q)
          tape_buffer_pkg::TAPE_STOP: begin
            if (data_above_motion || (flush_req && !empty)) begin
              tape_st_d = tape_buffer_pkg::TAPE_MOVE;
            end
          end
          tape_buffer_pkg::TAPE_MOVE: begin
            if (empty) begin
              tape_st_d = tape_buffer_pkg::TAPE_STOP;
            end
          end
          default: tape_st_d = tape_buffer_pkg::TAPE_STOP;
        endcase
      end
      2'b00: begin
        case (tape_st_q)
          tape_buffer_pkg::TAPE_STOP: begin
            if (free_above_motion) begin
              tape_st_d = tape_buffer_pkg::TAPE_MOVE;
            end
          end
          tape_buffer_pkg::TAPE_MOVE: begin
            if (full) begin
              tape_st_d = tape_buffer_pkg::TAPE_STOP;
            end
          end
          default: tape_st_d = tape_buffer_pkg::TAPE_STOP;
        endcase
      end
      // streaming: tape keeps moving while there is work on its side
      2'b11: tape_st_d = empty ? tape_buffer_pkg::TAPE_STOP : tape_buffer_pkg::TAPE_MOVE;
      2'b01: tape_st_d = full ? tape_buffer_pkg::TAPE_STOP : tape_buffer_pkg::TAPE_MOVE;
      default: tape_st_d = tape_buffer_pkg::TAPE_STOP;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tape_st_q <= tape_buffer_pkg::TAPE_STOP;
    end else begin
      tape_st_q <= tape_st_d;
    end
  end

  // host connection
  always_comb begin
    host_st_d = host_st_q;
    case ({dir_write, stream_q})
      2'b11: begin
        case (host_st_q)
          tape_buffer_pkg::HOST_ON: begin
            if (full) begin
              host_st_d = tape_buffer_pkg::HOST_OFF;
            end
          end
          tape_buffer_pkg::HOST_OFF: begin
            if (free_above_recon) begin
              host_st_d = tape_buffer_pkg::HOST_ON;
            end
          end
          default: host_st_d = tape_buffer_pkg::HOST_OFF;
        endcase
      end
      2'b01: begin
        case (host_st_q)
          tape_buffer_pkg::HOST_ON: begin
            if (empty) begin
              host_st_d = tape_buffer_pkg::HOST_OFF;
            end
          end
          tape_buffer_pkg::HOST_OFF: begin
            if (data_above_recon) begin
              host_st_d = tape_buffer_pkg::HOST_ON;
            end
          end
          default: host_st_d = tape_buffer_pkg::HOST_OFF;
        endcase
      end
      // start/stop: host is the slow side, served whenever the buffer allows
      2'b10: host_st_d = full ? tape_buffer_pkg::HOST_OFF : tape_buffer_pkg::HOST_ON;
      2'b00: host_st_d = empty ? tape_buffer_pkg::HOST_OFF : tape_buffer_pkg::HOST_ON;
      default: host_st_d = tape_buffer_pkg::HOST_OFF;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_st_q <= tape_buffer_pkg::HOST_OFF;
    end else begin
      host_st_q <= host_st_d;
    end
  end

  assign tape_motion_q = (tape_st_q == tape_buffer_pkg::TAPE_MOVE);
  assign host_conn_q = (host_st_q == tape_buffer_pkg::HOST_ON);
  assign occ_units_q = occ_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      free_units_q <= tape_buffer_pkg::CAP_UNITS;
    end else begin
      free_units_q <= tape_buffer_pkg::CAP_UNITS - occ_units_next(occ_q, fill, drain);
    end
  end

  function automatic logic [8:0] occ_units_next(input logic [8:0] o, input logic f, input logic d);
    occ_units_next = o;
    if (f && !d && o != tape_buffer_pkg::CAP_UNITS) begin
      occ_units_next = o + 9'h001;
    end else if (d && !f && o != 9'h000) begin
      occ_units_next = o - 9'h001;
    end
  endfunction

  // checks
  sequence ss_write;
    dir_write && !stream_q;
  endsequence

  sequence ss_read;
    !dir_write && !stream_q;
  endsequence

  sequence st_write;
    dir_write && stream_q;
  endsequence

  sequence st_read;
    !dir_write && stream_q;
  endsequence

  // first edge out of reset: both thresholds must be back at their defaults
  motion_default_a: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> motion_thr_q == tape_buffer_pkg::THR_RESET && recon_thr_q == tape_buffer_pkg::THR_RESET)
    else $error("threshold not at its default after reset");

  motion_hold_a: assert property (@(posedge clk) disable iff (rst)
    !(cmd_valid && cmd_opcode == tape_buffer_pkg::OP_MODE_SELECT && cmd_sel == tape_buffer_pkg::SEL_MOTION)
      |=> $stable(motion_thr_q))
    else $error("motion threshold changed without mode select");

  recon_hold_a: assert property (@(posedge clk) disable iff (rst)
    !(cmd_valid && cmd_opcode == tape_buffer_pkg::OP_MODE_SELECT && cmd_sel == tape_buffer_pkg::SEL_RECON)
      |=> $stable(recon_thr_q))
    else $error("reconnect threshold changed without mode select");

  ready_gate_a: assert property (@(posedge clk) disable iff (rst)
    !(full && (dir_write ? host_ready : tape_ready)) && !(empty && (dir_write ? tape_ready : host_ready)))
    else $error("unit accepted past full or empty");

  flush_start_a: assert property (@(posedge clk) disable iff (rst)
    ss_write and (!tape_motion_q && flush_req && !empty) |=> tape_motion_q)
    else $error("start/stop write ignored a flush request");

  wr_drain_a: assert property (@(posedge clk) disable iff (rst)
    st_write and !empty |=> tape_motion_q)
    else $error("streaming write stopped draining with data held");

  thr_write_a: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && cmd_opcode == tape_buffer_pkg::OP_MODE_SELECT && cmd_sel == tape_buffer_pkg::SEL_MOTION
      |=> motion_thr_q == $past(cmd_value))
    else $error("motion threshold not taken from mode select");

  recon_write_a: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && cmd_opcode == tape_buffer_pkg::OP_MODE_SELECT && cmd_sel == tape_buffer_pkg::SEL_RECON
      |=> recon_thr_q == $past(cmd_value))
    else $error("reconnect threshold not taken from mode select");

  occ_bound_a: assert property (@(posedge clk) disable iff (rst)
    occ_q <= tape_buffer_pkg::CAP_UNITS && free_units_q == tape_buffer_pkg::CAP_UNITS - occ_q)
    else $error("occupancy out of range or free space wrong");

  write_start_a: assert property (@(posedge clk) disable iff (rst)
    ss_write and (!tape_motion_q && data_above_motion) |=> tape_motion_q)
    else $error("start/stop write did not start above threshold");

  write_hold_a: assert property (@(posedge clk) disable iff (rst)
    ss_write and (!tape_motion_q && !data_above_motion && !flush_req) |=> !tape_motion_q)
    else $error("start/stop write started early");

  write_halt_a: assert property (@(posedge clk) disable iff (rst)
    ss_write and (tape_motion_q && !empty) |=> tape_motion_q)
    else $error("start/stop write halted before empty");

  read_start_a: assert property (@(posedge clk) disable iff (rst)
    ss_read and (!tape_motion_q && !free_above_motion) |=> !tape_motion_q)
    else $error("start/stop read started without free space");

  read_halt_a: assert property (@(posedge clk) disable iff (rst)
    ss_read and (tape_motion_q && full) |=> !tape_motion_q)
    else $error("start/stop read did not halt on full");

  wr_disc_a: assert property (@(posedge clk) disable iff (rst)
    st_write and full |=> !host_conn_q && tape_motion_q)
    else $error("streaming write did not disconnect on full");

  wr_recon_a: assert property (@(posedge clk) disable iff (rst)
    st_write and (!host_conn_q && free_above_recon) |=> host_conn_q)
    else $error("streaming write did not reconnect");

  rd_disc_a: assert property (@(posedge clk) disable iff (rst)
    st_read and empty |=> !host_conn_q && tape_motion_q)
    else $error("streaming read did not disconnect on empty");

  rd_recon_a: assert property (@(posedge clk) disable iff (rst)
    st_read and (!host_conn_q && !data_above_recon) |=> !host_conn_q)
    else $error("streaming read reconnected early");

  mode_pick_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> stream_q == ($past(host_rate) >= tape_buffer_pkg::tape_rate($past(fmt))))
    else $error("streaming choice wrong for format rate");
endmodule // tape_buffer_ctrl

/* File: test/far_side.sv */
// Purpose: host and tape transport model that moves 4-KByte units
// Assumes: a unit is offered and held until ready is sampled high at a rising edge
// Notes: a gap between units models a slow party; a wait limit keeps a refused unit from hanging

`timescale 1ns/100ps

module far_side (
  // clock
  input wire logic clk,
  // readiness from the buffer control
  input wire logic host_ready,
  input wire logic tape_ready,
  // unit strobes
  output logic host_unit,
  output logic tape_unit
);
  initial begin
    host_unit = 1'b0;
    tape_unit = 1'b0;
  end

  // offer n units on one side, gap idle cycles after each
  task automatic burst(input bit tape, input int n, input int gap);
    int w;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (tape) begin
        tape_unit <= 1'b1;
      end else begin
        host_unit <= 1'b1;
      end
      w = 0;
      do begin
        @(posedge clk);
        w++;
      end while (!(tape ? tape_ready : host_ready) && w < 400);
      tape_unit <= 1'b0;
      host_unit <= 1'b0;
      repeat (gap) @(posedge clk);
    end
  endtask
endmodule // far_side

/* File: test/tb_top.sv */
// Purpose: self-checking bench for the tape buffer threshold control
// Assumes: far_side moves units with a hold-until-ready handshake
// Notes: thresholds are reprogrammed by mode select: motion to 02h and later FAh, reconnect to a value from 10h to 1Fh

`timescale 1ns/100ps

module tb_top;
  logic clk, rst, cmd_valid, cmd_sel, dir_write, flush_req;
  logic [7:0] cmd_opcode, cmd_value, r;
  logic [15:0] host_rate;
  tape_buffer_pkg::fmt_e fmt;
  logic host_unit, tape_unit, host_ready, tape_ready, tape_motion_q, host_conn_q, stream_q;
  logic [8:0] occ_units_q, free_units_q;
  logic [7:0] motion_thr_q, recon_thr_q;
  logic [31:0] seed = 32'h38AE;
  int errors = 0;
  int compares = 0;
  // each note is a 4-bit selector of the output and the 9-bit expected value
  logic [12:0] q[$];
  event noted;

  tape_buffer_ctrl i_tape_buffer_ctrl (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_sel(cmd_sel), .cmd_value(cmd_value), .dir_write(dir_write), .fmt(fmt), .host_rate(host_rate),
    .flush_req(flush_req), .host_unit(host_unit), .tape_unit(tape_unit), .host_ready(host_ready),
    .tape_ready(tape_ready), .tape_motion_q(tape_motion_q), .host_conn_q(host_conn_q), .stream_q(stream_q),
    .occ_units_q(occ_units_q), .free_units_q(free_units_q), .motion_thr_q(motion_thr_q),
    .recon_thr_q(recon_thr_q));

  far_side i_far_side (.clk(clk), .host_ready(host_ready), .tape_ready(tape_ready), .host_unit(host_unit),
    .tape_unit(tape_unit));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [15:0] rate_of(input int f);
    case (f)
      0: return tape_buffer_pkg::RATE_1M;
      1, 2: return tape_buffer_pkg::RATE_500K;
      default: return tape_buffer_pkg::RATE_262K5;
    endcase
  endfunction

  task automatic note(input logic [3:0] sel, input logic [8:0] v);
    q.push_back({sel, v});
    -> noted;
  endtask

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // let n edges pass, then step off the edge so outputs are settled
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic mode_sel(input logic [7:0] op, input logic sel, input logic [7:0] val);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_opcode <= op;
    cmd_sel <= sel;
    cmd_value <= val;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin : monitor
    logic [12:0] e;
    logic [8:0] s;
    forever begin
      @(noted);
      while (q.size() > 0) begin
        e = q.pop_front();
        case (e[12:9])
          4'h0: s = {8'h00, tape_motion_q};
          4'h1: s = {8'h00, host_conn_q};
          4'h2: s = {8'h00, stream_q};
          4'h3: s = occ_units_q;
          4'h4: s = free_units_q;
          4'h5: s = {1'b0, motion_thr_q};
          4'h6: s = {1'b0, recon_thr_q};
          4'h7: s = {8'h00, host_ready};
          default: s = {8'h00, tape_ready};
        endcase
        check(s, e[8:0]);
      end
    end
  end

  // generous bound: the longest run is a few thousand cycles
  initial begin
    repeat (8000) @(posedge clk);
    errors++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_opcode = 8'h00;
    cmd_sel = 1'b0;
    cmd_value = 8'h00;
    dir_write = 1'b1;
    fmt = tape_buffer_pkg::FMT_HI;
    host_rate = 16'h0001;
    flush_req = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    note(4'h5, 9'h080);
    note(4'h6, 9'h080);
    note(4'h3, 9'h000);
    note(4'h4, 9'h100);
    $display("test reset done");
    mode_sel(8'h16, 1'b0, 8'h55);
    wt(1);
    note(4'h5, 9'h080);
    seed = lfsr(seed);
    r = 8'h10 + {4'h0, seed[3:0]};
    mode_sel(8'h15, 1'b0, 8'h02);
    mode_sel(8'h15, 1'b1, r);
    wt(1);
    note(4'h5, 9'h002);
    note(4'h6, {1'b0, r});
    $display("test mode select done");
    i_far_side.burst(1'b0, 2, 0);
    wt(3);
    note(4'h0, 9'h000);
    note(4'h3, 9'h002);
    i_far_side.burst(1'b0, 1, 0);
    wt(1);
    note(4'h0, 9'h001);
    i_far_side.burst(1'b1, 3, 1);
    wt(2);
    note(4'h3, 9'h000);
    note(4'h0, 9'h000);
    note(4'h8, 9'h000);
    i_far_side.burst(1'b0, 1, 0);
    wt(3);
    note(4'h0, 9'h000);
    @(posedge clk);
    flush_req <= 1'b1;
    i_far_side.burst(1'b1, 1, 0);
    flush_req <= 1'b0;
    wt(2);
    note(4'h3, 9'h000);
    note(4'h0, 9'h000);
    $display("test start stop write done");
    @(posedge clk);
    dir_write <= 1'b0;
    i_far_side.burst(1'b1, 256, 0);
    wt(2);
    note(4'h3, 9'h100);
    note(4'h4, 9'h000);
    note(4'h0, 9'h000);
    note(4'h8, 9'h000);
    mode_sel(8'h15, 1'b0, 8'hFA);
    i_far_side.burst(1'b0, 250, 0);
    wt(2);
    note(4'h0, 9'h000);
    i_far_side.burst(1'b0, 1, 0);
    wt(1);
    note(4'h0, 9'h001);
    $display("test start stop read done");
    @(posedge clk);
    host_rate <= 16'hFFFF;
    dir_write <= 1'b1;
    wt(2);
    note(4'h2, 9'h001);
    i_far_side.burst(1'b0, 251, 0);
    wt(2);
    note(4'h1, 9'h000);
    note(4'h0, 9'h001);
    note(4'h7, 9'h000);
    note(4'h8, 9'h001);
    i_far_side.burst(1'b1, int'(r), 0);
    wt(2);
    note(4'h1, 9'h000);
    i_far_side.burst(1'b1, 1, 0);
    wt(2);
    note(4'h1, 9'h001);
    note(4'h7, 9'h001);
    $display("test streaming write done");
    @(posedge clk);
    dir_write <= 1'b0;
    i_far_side.burst(1'b0, 255 - int'(r), 0);
    wt(2);
    note(4'h1, 9'h000);
    note(4'h0, 9'h001);
    note(4'h7, 9'h000);
    note(4'h8, 9'h001);
    i_far_side.burst(1'b1, int'(r), 0);
    wt(2);
    note(4'h1, 9'h000);
    i_far_side.burst(1'b1, 1, 0);
    wt(2);
    note(4'h1, 9'h001);
    note(4'h7, 9'h001);
    $display("test streaming read done");
    for (int f = 0; f < 4; f++) begin
      @(posedge clk);
      fmt <= tape_buffer_pkg::fmt_e'(f[1:0]);
      host_rate <= rate_of(f) - 16'h0001;
      wt(2);
      note(4'h2, 9'h000);
      @(posedge clk);
      host_rate <= rate_of(f);
      wt(2);
      note(4'h2, 9'h001);
    end
    $display("test mode choice done");
    // reset in mid-run must drop the reprogrammed thresholds and the count
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    note(4'h5, 9'h080);
    note(4'h6, 9'h080);
    note(4'h3, 9'h000);
    note(4'h4, 9'h100);
    $display("test second reset done");
    wt(1);
    finish_test();
  end
endmodule // tb_top
